// *** verilog/msd_defs.vh ***
/*
  constants for the memory space decoder: address ranges, region
  codes, fill values and the flash page select bit.
  assumes it is included by bare name from verilog/ sources.
*/
//  Overview of operation
//  - register file is 4096 bytes, 12-bit addresses
//  - F00H-FFFH go to control registers, not RAM
//  - unassigned control locations read undefined; avoid writes
//  - RAM starts at 000H, sized 256 B to 1 KB
//  - gap above RAM reads undefined, writes ignored
//  - 64 KB program space, flash 1-8 KB low
//  - program reads beyond flash return FFH
//  - program writes beyond flash change nothing
//  - bottom: option, reset, watchdog, illegal-trap vectors
//  - interrupt vectors, reserved, oscillator-fail, code at 003E
//  - no data memory; data space maps nowhere
//  - page select bit 7 enables information area
//  - enabled: FE00H-FF7FH reads return information bytes
//  - information area is read-only through overlay
//  - FE40-FE53 hold 20-char identifier, FFH padded
//  - absent peripheral registers behave as reserved
`ifndef MSD_DEFS_VH
`define MSD_DEFS_VH

// ----------------------------------------------------------------
// register file
// ----------------------------------------------------------------
`define MSD_RF_AW        12
`define MSD_CTRL_BASE    12'hF00
`define MSD_FPS_ADDR     12'hFF9
`define MSD_FPS_INFO_BIT 7
`define MSD_RF_UNDEF     8'h00

// ----------------------------------------------------------------
// register file target codes
// ----------------------------------------------------------------
`define MSD_RT_NONE 2'h0
`define MSD_RT_RAM  2'h1
`define MSD_RT_CTRL 2'h2
`define MSD_RT_FPS  2'h3

// ----------------------------------------------------------------
// program space
// ----------------------------------------------------------------
`define MSD_PM_AW        16
`define MSD_INFO_BASE    16'hFE00
`define MSD_INFO_LAST    16'hFF7F
`define MSD_INFO_AW      7
`define MSD_PART_FIRST   7'h40
`define MSD_PART_CHARS   20
`define MSD_FILL_BYTE    8'hFF

// ----------------------------------------------------------------
// fixed vector layout, first address of each region
// ----------------------------------------------------------------
`define MSD_VEC_RESET    16'h0002
`define MSD_VEC_WATCHDOG 16'h0004
`define MSD_VEC_ILLEGAL  16'h0006
`define MSD_VEC_IRQ      16'h0008
`define MSD_VEC_RSVD     16'h0038
`define MSD_VEC_OSCFAIL  16'h003A
`define MSD_CODE_START   16'h003E

// ----------------------------------------------------------------
// program region codes
// ----------------------------------------------------------------
`define MSD_PR_OPTION   4'h0
`define MSD_PR_RESET    4'h1
`define MSD_PR_WATCHDOG 4'h2
`define MSD_PR_ILLEGAL  4'h3
`define MSD_PR_IRQ      4'h4
`define MSD_PR_RSVD     4'h5
`define MSD_PR_OSCFAIL  4'h6
`define MSD_PR_CODE     4'h7
`define MSD_PR_UNIMPL   4'h8
`define MSD_PR_INFO     4'h9

// ----------------------------------------------------------------
// program data source codes
// ----------------------------------------------------------------
`define MSD_PS_FLASH 2'h0
`define MSD_PS_INFO  2'h1
`define MSD_PS_FILL  2'h2

`endif

// *** verilog/msd_info_rom.v ***
/*
  read-only information area: 128 bytes, indexed by offset from
  the overlay base. calibration bytes read as fill; the identifier
  text sits at its fixed offset.
  assumes the index comes from a flip-flop in the parent.
*/
`timescale 1ns/1ns
`default_nettype none
`include "msd_defs.vh"

module msd_info_rom #(
  parameter [8*`MSD_PART_CHARS-1:0] PART_ID  = "GENERIC-MCU-8",  // arbitrary text
  parameter integer                 PART_LEN = 13                  // chars used in PART_ID
) (
  // index into the area
  input  wire [`MSD_INFO_AW-1:0] info_idx,
  // byte at that index
  output reg  [7:0]              info_data
);

  // ----------------------------------------------------------------
  // lookup
  // ----------------------------------------------------------------
  reg [`MSD_INFO_AW-1:0] pos;  // position inside identifier

  // identifier left aligned, tail padded with fill
  always @* begin
    pos       = info_idx - `MSD_PART_FIRST;
    info_data = `MSD_FILL_BYTE;
    if (info_idx >= `MSD_PART_FIRST &&
        pos < `MSD_PART_CHARS && pos < PART_LEN) begin
      // string literal is right aligned, so count from its top char
      info_data = PART_ID[8*(PART_LEN-1-pos) +: 8];
    end
  end

endmodule
`default_nettype wire

// *** verilog/msd_decoder.v ***
/*
  memory space decoder: steers register file, program and data
  accesses of the core to RAM, control registers, flash or the
  information overlay, and supplies fill values elsewhere.
  assumes targets return read data combinationally from the
  registered address they are given, one cycle before capture.
*/
`timescale 1ns/1ns
`default_nettype none
`include "msd_defs.vh"

module msd_decoder #(
  parameter integer RAM_BYTES   = 1024,  // 256 to 1024
  parameter integer RAM_AW      = 10,    // ram index width
  parameter integer FLASH_BYTES = 8192,  // 1024 to 8192
  parameter integer FLASH_AW    = 13     // flash index width
) (
  // clock and reset
  input  wire                    clk_sys,
  input  wire                    rst_n,
  // register file request from core
  input  wire [`MSD_RF_AW-1:0]   rf_addr,
  input  wire                    rf_rd,
  input  wire                    rf_wr,
  input  wire [7:0]              rf_wdata,
  // register file answer
  output reg  [7:0]              rf_rdata,
  output reg                     rf_valid,
  // ram target
  output reg  [RAM_AW-1:0]       ram_addr,
  output reg                     ram_re,
  output reg                     ram_we,
  output reg  [7:0]              ram_wdata,
  input  wire [7:0]              ram_rdata,
  // control register target
  output reg  [7:0]              ctrl_addr,
  output reg                     ctrl_re,
  output reg                     ctrl_we,
  output reg  [7:0]              ctrl_wdata,
  input  wire                    ctrl_claim,
  input  wire [7:0]              ctrl_rdata,
  // program request from core
  input  wire [`MSD_PM_AW-1:0]   pm_addr,
  input  wire                    pm_rd,
  input  wire                    pm_wr,
  input  wire [7:0]              pm_wdata,
  // program answer
  output reg  [7:0]              pm_rdata,
  output reg                     pm_valid,
  output reg  [3:0]              pm_region,
  // flash target
  output reg  [FLASH_AW-1:0]     flash_addr,
  output reg                     flash_re,
  output reg                     flash_we,
  output reg  [7:0]              flash_wdata,
  input  wire [7:0]              flash_rdata,
  // data space request and answer
  input  wire                    dm_rd,
  input  wire                    dm_wr,
  output reg  [7:0]              dm_rdata,
  output reg                     dm_valid,
  // overlay state
  output reg                     info_en
);

  // ----------------------------------------------------------------
  // decode functions
  // ----------------------------------------------------------------
  // register file target for an address
  function [1:0] rf_class;
    input [`MSD_RF_AW-1:0] a;
    begin
      if (a == `MSD_FPS_ADDR) begin
        rf_class = `MSD_RT_FPS;
      end else if (a >= `MSD_CTRL_BASE) begin
        rf_class = `MSD_RT_CTRL;  // top 256 bytes
      end else if (a < RAM_BYTES) begin
        rf_class = `MSD_RT_RAM;   // ram from 000H up
      end else begin
        rf_class = `MSD_RT_NONE;  // gap above ram
      end
    end
  endfunction

  // overlay window test, used for reads and writes
  function in_info;
    input [`MSD_PM_AW-1:0] a;
    begin
      in_info = (a >= `MSD_INFO_BASE) && (a <= `MSD_INFO_LAST);
    end
  endfunction

  // program region of an address
  function [3:0] pm_class;
    input [`MSD_PM_AW-1:0] a;
    input                  ovl;
    begin
      if (ovl && in_info(a)) begin
        pm_class = `MSD_PR_INFO;
      end else if (a >= FLASH_BYTES) begin
        pm_class = `MSD_PR_UNIMPL;     // past last flash byte
      end else if (a < `MSD_VEC_RESET) begin
        pm_class = `MSD_PR_OPTION;
      end else if (a < `MSD_VEC_WATCHDOG) begin
        pm_class = `MSD_PR_RESET;
      end else if (a < `MSD_VEC_ILLEGAL) begin
        pm_class = `MSD_PR_WATCHDOG;
      end else if (a < `MSD_VEC_IRQ) begin
        pm_class = `MSD_PR_ILLEGAL;
      end else if (a < `MSD_VEC_RSVD) begin
        pm_class = `MSD_PR_IRQ;
      end else if (a < `MSD_VEC_OSCFAIL) begin
        pm_class = `MSD_PR_RSVD;
      end else if (a < `MSD_CODE_START) begin
        pm_class = `MSD_PR_OSCFAIL;
      end else begin
        pm_class = `MSD_PR_CODE;
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // internal state
  // ----------------------------------------------------------------
  reg [1:0]              rf_tgt;    // target of pending rf read
  reg                    rf_pend;   // rf read awaiting capture
  reg                    ctrl_own;  // pending ctrl read was claimed
  reg [1:0]              pm_src;    // source of pending pm read
  reg                    pm_pend;   // pm read awaiting capture
  reg [`MSD_INFO_AW-1:0] info_idx;  // overlay byte index
  reg                    dm_pend;   // data read awaiting answer
  wire [7:0]             info_data; // overlay byte
  wire [1:0]             next_rf_tgt;
  wire [3:0]             next_region;

  assign next_rf_tgt = rf_class(rf_addr);
  assign next_region = pm_class(pm_addr, info_en);

  // ----------------------------------------------------------------
  // information area
  // ----------------------------------------------------------------
  msd_info_rom u_info (
    .info_idx  (info_idx),
    .info_data (info_data)
  );

  // ----------------------------------------------------------------
  // register file stage: steer strobes to the target
  // ----------------------------------------------------------------
  // only 12 address bits exist, so nothing outside 4096 bytes
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      ram_addr   <= {RAM_AW{1'b0}};
      ram_re     <= 1'b0;
      ram_we     <= 1'b0;
      ram_wdata  <= 8'h00;
      ctrl_addr  <= 8'h00;
      ctrl_re    <= 1'b0;
      ctrl_we    <= 1'b0;
      ctrl_wdata <= 8'h00;
      rf_tgt     <= `MSD_RT_NONE;
      rf_pend    <= 1'b0;
      info_en    <= 1'b0;  // normal flash visible after reset
    end else begin
      ram_addr   <= rf_addr[RAM_AW-1:0];
      ram_wdata  <= rf_wdata;
      ctrl_addr  <= rf_addr[7:0];
      ctrl_wdata <= rf_wdata;
      // ram strobes only inside implemented ram
      ram_re     <= rf_rd && (next_rf_tgt == `MSD_RT_RAM);
      ram_we     <= rf_wr && (next_rf_tgt == `MSD_RT_RAM);
      // writes in the gap reach no target at all
      ctrl_re    <= rf_rd && (next_rf_tgt == `MSD_RT_CTRL);
      ctrl_we    <= rf_wr && (next_rf_tgt == `MSD_RT_CTRL);
      rf_tgt     <= next_rf_tgt;
      rf_pend    <= rf_rd;
      // page select held here; only bit 7 matters to this block
      if (rf_wr && next_rf_tgt == `MSD_RT_FPS) begin
        info_en <= rf_wdata[`MSD_FPS_INFO_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // register file answer
  // ----------------------------------------------------------------
  // ctrl_claim is sampled against the registered ctrl_addr
  always @* begin
    ctrl_own = ctrl_claim;
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      rf_rdata <= 8'h00;
      rf_valid <= 1'b0;
    end else begin
      rf_valid <= rf_pend;
      if (rf_tgt == `MSD_RT_RAM) begin
        rf_rdata <= ram_rdata;
      end else if (rf_tgt == `MSD_RT_FPS) begin
        rf_rdata <= {info_en, 7'h00};
      end else if (rf_tgt == `MSD_RT_CTRL && ctrl_own) begin
        rf_rdata <= ctrl_rdata;
      end else begin
        // unassigned or absent register: no meaningful value
        rf_rdata <= `MSD_RF_UNDEF;
      end
    end
  end

  // ----------------------------------------------------------------
  // program stage: flash strobes and overlay select
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      flash_addr  <= {FLASH_AW{1'b0}};
      flash_re    <= 1'b0;
      flash_we    <= 1'b0;
      flash_wdata <= 8'h00;
      pm_src      <= `MSD_PS_FILL;
      pm_pend     <= 1'b0;
      pm_region   <= `MSD_PR_OPTION;
      info_idx    <= {`MSD_INFO_AW{1'b0}};
    end else begin
      flash_addr  <= pm_addr[FLASH_AW-1:0];
      flash_wdata <= pm_wdata;
      info_idx    <= pm_addr[`MSD_INFO_AW-1:0];
      pm_pend     <= pm_rd;
      if (pm_rd || pm_wr) begin
        pm_region <= next_region;
      end
      // 16-bit address covers the 64 KB space
      flash_re <= pm_rd && (next_region != `MSD_PR_UNIMPL) &&
                  (next_region != `MSD_PR_INFO);
      // overlay and unimplemented writes are dropped
      flash_we <= pm_wr && (next_region != `MSD_PR_UNIMPL) &&
                  !(info_en && in_info(pm_addr));
      if (next_region == `MSD_PR_INFO) begin
        pm_src <= `MSD_PS_INFO;
      end else if (next_region == `MSD_PR_UNIMPL) begin
        pm_src <= `MSD_PS_FILL;
      end else begin
        pm_src <= `MSD_PS_FLASH;
      end
    end
  end

  // ----------------------------------------------------------------
  // program answer
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      pm_rdata <= 8'h00;
      pm_valid <= 1'b0;
    end else begin
      pm_valid <= pm_pend;
      if (pm_src == `MSD_PS_INFO) begin
        pm_rdata <= info_data;
      end else if (pm_src == `MSD_PS_FLASH) begin
        pm_rdata <= flash_rdata;
      end else begin
        pm_rdata <= `MSD_FILL_BYTE;
      end
    end
  end

  // ----------------------------------------------------------------
  // data space: nothing behind it
  // ----------------------------------------------------------------
  // same two-cycle latency as the other spaces keeps the core simple
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      dm_pend  <= 1'b0;
      dm_valid <= 1'b0;
      dm_rdata <= 8'h00;
    end else begin
      dm_pend  <= dm_rd;
      dm_valid <= dm_pend;
      dm_rdata <= `MSD_FILL_BYTE;
    end
  end

endmodule
`default_nettype wire

// *** bench/msd_chk.sv ***
/* port checker for msd_decoder.
   assumes msd_defs.vh on the include path; bound by the line at the foot. */
`timescale 1ns/1ns
`default_nettype none
`include "msd_defs.vh"
module msd_chk #(
  parameter integer RAM_BYTES   = 1024,  // ram size
  parameter integer FLASH_BYTES = 8192   // flash size
) (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        rst_n,
  // register file side
  input wire logic [11:0] rf_addr,
  input wire logic        rf_rd,
  input wire logic        rf_wr,
  input wire logic [7:0]  rf_wdata,
  input wire logic        rf_valid,
  input wire logic        ram_re,
  input wire logic        ram_we,
  input wire logic [7:0]  ctrl_addr,
  input wire logic        ctrl_re,
  input wire logic        ctrl_we,
  // program and data side
  input wire logic [15:0] pm_addr,
  input wire logic        pm_rd,
  input wire logic        pm_wr,
  input wire logic [7:0]  pm_rdata,
  input wire logic        pm_valid,
  input wire logic [3:0]  pm_region,
  input wire logic        flash_we,
  input wire logic        dm_rd,
  input wire logic [7:0]  dm_rdata,
  input wire logic        dm_valid,
  input wire logic        info_en
);
  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  wire ovl = (pm_addr >= 16'hFE00) && (pm_addr <= 16'hFF7F);  // overlay window
  wire fps = (rf_addr == `MSD_FPS_ADDR);                      // page select hit
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // -----------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------
  ram_route_a: assert property (rf_rd && rf_addr < RAM_BYTES |=> ram_re && !ctrl_re)
    else $error("ram read not steered to ram");
  gap_quiet_a: assert property ((rf_rd || rf_wr) && rf_addr >= RAM_BYTES
    && rf_addr < 12'hF00 |=> !(ram_re || ram_we || ctrl_re || ctrl_we))
    else $error("gap access strobed a target");
  ctrl_route_a: assert property (rf_rd && rf_addr >= 12'hF00 && !fps
    |=> ctrl_re && !ram_re && ctrl_addr == $past(rf_addr[7:0]))
    else $error("control read misrouted");
  rf_answer_a: assert property (rf_rd |-> ##2 rf_valid)
    else $error("register read answer late");
  pm_fill_a: assert property (pm_rd && pm_addr >= FLASH_BYTES && !(info_en && ovl)
    |-> ##2 pm_valid && pm_rdata == 8'hFF)
    else $error("unimplemented program read not FF");
  pm_nowrite_a: assert property (pm_wr && pm_addr >= FLASH_BYTES |=> !flash_we)
    else $error("write beyond flash strobed flash");
  info_ro_a: assert property (pm_wr && info_en && ovl |=> !flash_we)
    else $error("overlay write reached flash");
  dm_fill_a: assert property (dm_rd |-> ##2 dm_valid && dm_rdata == 8'hFF)
    else $error("data space read not FF");
  info_set_a: assert property (rf_wr && fps |=> info_en == $past(rf_wdata[7]))
    else $error("enable bit not taken");
  info_hold_a: assert property (!(rf_wr && fps) |=> $stable(info_en))
    else $error("enable changed without write");
  reset_clear_a: assert property ($rose(rst_n) |-> !info_en)
    else $error("enable set after reset");
  vec_region_a: assert property (pm_rd && pm_addr[15:1] == 15'h1 |=> pm_region == 4'h1)
    else $error("reset vector region wrong");
  code_region_a: assert property (pm_rd && pm_addr >= 16'h003E
    && pm_addr < FLASH_BYTES |=> pm_region == 4'h7)
    else $error("code region wrong");
  // main scenarios reached
  fps_cov: cover property (rf_wr && fps && rf_wdata[7]);
  ovl_cov: cover property (pm_rd && info_en && ovl);
  dm_cov: cover property (dm_rd);
endmodule
bind msd_decoder msd_chk #(.RAM_BYTES(RAM_BYTES), .FLASH_BYTES(FLASH_BYTES)) u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .rf_addr(rf_addr), .rf_rd(rf_rd), .rf_wr(rf_wr),
  .rf_wdata(rf_wdata), .rf_valid(rf_valid), .ram_re(ram_re), .ram_we(ram_we),
  .ctrl_addr(ctrl_addr), .ctrl_re(ctrl_re), .ctrl_we(ctrl_we), .pm_addr(pm_addr),
  .pm_rd(pm_rd), .pm_wr(pm_wr), .pm_rdata(pm_rdata), .pm_valid(pm_valid),
  .pm_region(pm_region), .flash_we(flash_we), .dm_rd(dm_rd), .dm_rdata(dm_rdata),
  .dm_valid(dm_valid), .info_en(info_en));
`default_nettype wire

// *** bench/msd_targets.sv ***
/* far-side targets: ram, a few control registers and flash.
   assumes the decoder samples read data only while it strobes. */
`timescale 1ns/1ns
`default_nettype none
module msd_targets #(
  parameter integer RAM_AW   = 8,   // ram index width
  parameter integer FLASH_AW = 10   // flash index width
) (
  // clock
  input wire logic                clk_sys,
  // ram
  input wire logic [RAM_AW-1:0]   ram_addr,
  input wire logic                ram_re,
  input wire logic                ram_we,
  input wire logic [7:0]          ram_wdata,
  output logic     [7:0]          ram_rdata,
  // control registers
  input wire logic [7:0]          ctrl_addr,
  input wire logic                ctrl_re,
  output logic                    ctrl_claim,
  output logic     [7:0]          ctrl_rdata,
  // flash
  input wire logic [FLASH_AW-1:0] flash_addr,
  input wire logic                flash_re,
  input wire logic                flash_we,
  input wire logic [7:0]          flash_wdata,
  output logic     [7:0]          flash_rdata
);
  logic [7:0]          mem [0:(1<<RAM_AW)-1];  // ram cells
  logic                fl_hit = 1'b0;          // some flash write has landed
  logic [FLASH_AW-1:0] fl_at;                  // where the last one landed
  logic [7:0]          fl_val;                 // and what it wrote
  logic [7:0]          fl_base;                // flash cell as stored
  // flash keeps only its last write, enough to catch a stray strobe
  always @(posedge clk_sys) begin
    if (flash_we) begin
      fl_hit <= 1'b1;
      fl_at  <= flash_addr;
      fl_val <= flash_wdata;
    end
  end
  assign fl_base = (fl_hit && fl_at == flash_addr) ? fl_val : flash_addr[7:0] + 8'h11;
  // ram write port
  always @(posedge clk_sys) begin
    if (ram_we) begin
      mem[ram_addr] <= ram_wdata;
    end
  end
  // unselected targets show inverted data so stale reads get caught
  assign ram_rdata   = ram_re ? mem[ram_addr] : ~mem[ram_addr];
  assign ctrl_claim  = (ctrl_addr[7:4] == 4'h0);  // only F00-F0F present
  assign ctrl_rdata  = ctrl_re ? (ctrl_addr ^ 8'h3C) : ~(ctrl_addr ^ 8'h3C);
  assign flash_rdata = flash_re ? fl_base : ~fl_base;
endmodule
`default_nettype wire

// *** bench/msd_decoder_tb_top.sv ***
/* self-checking bench for msd_decoder with small ram and flash.
   assumes the info area keeps its default identifier text. */
`timescale 1ns/1ns
`default_nettype none
module msd_decoder_tb_top;
  localparam integer FLASH_BYTES = 1024;  // smallest flash
  logic        clk_sys, rst_n, rf_rd, rf_wr, pm_rd, pm_wr, dm_rd, dm_wr;
  logic [11:0] rf_addr;
  logic [15:0] pm_addr;
  logic [7:0]  rf_wdata, pm_wdata, rf_rdata, pm_rdata, dm_rdata, ram_rdata, ram_wdata;
  logic [7:0]  ctrl_addr, ctrl_wdata, ctrl_rdata, flash_rdata, flash_wdata, q;
  logic [7:0]  ram_addr;
  logic [9:0]  flash_addr;
  logic [3:0]  pm_region, r;
  logic        rf_valid, pm_valid, dm_valid, ram_re, ram_we, ctrl_re, ctrl_we, ctrl_claim;
  logic        flash_re, flash_we, info_en;
  int          errors, cmp_count, i;
  logic [15:0] vec [0:17] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h0005,
    16'h0006, 16'h0007, 16'h0008, 16'h0037, 16'h0038, 16'h0039, 16'h003A, 16'h003D,
    16'h003E, 16'h03FF, 16'h0400, 16'hFFFF};
  // -----------------------------------------------------------------
  // design and far side
  // -----------------------------------------------------------------
  msd_decoder #(.RAM_BYTES(256), .RAM_AW(8), .FLASH_BYTES(FLASH_BYTES), .FLASH_AW(10)) DUT (
    .clk_sys(clk_sys), .rst_n(rst_n), .rf_addr(rf_addr), .rf_rd(rf_rd), .rf_wr(rf_wr),
    .rf_wdata(rf_wdata), .rf_rdata(rf_rdata), .rf_valid(rf_valid), .ram_addr(ram_addr),
    .ram_re(ram_re), .ram_we(ram_we), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata),
    .ctrl_addr(ctrl_addr), .ctrl_re(ctrl_re), .ctrl_we(ctrl_we), .ctrl_wdata(ctrl_wdata),
    .ctrl_claim(ctrl_claim), .ctrl_rdata(ctrl_rdata), .pm_addr(pm_addr), .pm_rd(pm_rd),
    .pm_wr(pm_wr), .pm_wdata(pm_wdata), .pm_rdata(pm_rdata), .pm_valid(pm_valid),
    .pm_region(pm_region), .flash_addr(flash_addr), .flash_re(flash_re),
    .flash_we(flash_we), .flash_wdata(flash_wdata), .flash_rdata(flash_rdata),
    .dm_rd(dm_rd), .dm_wr(dm_wr), .dm_rdata(dm_rdata), .dm_valid(dm_valid),
    .info_en(info_en));
  msd_targets #(.RAM_AW(8), .FLASH_AW(10)) u_tgt (
    .clk_sys(clk_sys), .ram_addr(ram_addr), .ram_re(ram_re), .ram_we(ram_we),
    .ram_wdata(ram_wdata), .ram_rdata(ram_rdata), .ctrl_addr(ctrl_addr),
    .ctrl_re(ctrl_re), .ctrl_claim(ctrl_claim), .ctrl_rdata(ctrl_rdata),
    .flash_addr(flash_addr), .flash_re(flash_re), .flash_we(flash_we),
    .flash_wdata(flash_wdata), .flash_rdata(flash_rdata));
  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s exp %h got %h", what, exp, got);
    end
  endtask
  // one register file cycle; read data comes back within a bounded wait
  task automatic rf_go(input logic [11:0] a, input logic rd, input logic wr, input logic [7:0] d);
    @(posedge clk_sys);
    rf_addr <= a;
    rf_rd <= rd;
    rf_wr <= wr;
    rf_wdata <= d;
    @(posedge clk_sys);
    rf_rd <= 1'b0;
    rf_wr <= 1'b0;
    q = 8'hXX;
    for (int k = 0; k < 4 && rd; k++) begin
      @(negedge clk_sys);
      if (rf_valid === 1'b1) begin
        q = rf_rdata;
        break;
      end
    end
  endtask
  // one program cycle, returning data and region
  task automatic pm_go(input logic [15:0] a, input logic wr, input logic [7:0] d);
    @(posedge clk_sys);
    pm_addr <= a;
    pm_rd <= !wr;
    pm_wr <= wr;
    pm_wdata <= d;
    @(posedge clk_sys);
    pm_rd <= 1'b0;
    pm_wr <= 1'b0;
    q = 8'hXX;
    for (int k = 0; k < 4 && !wr; k++) begin
      @(negedge clk_sys);
      if (pm_valid === 1'b1) begin
        q = pm_rdata;
        r = pm_region;
        break;
      end
    end
  endtask
  // expected region code from the fixed layout
  function automatic logic [3:0] exp_reg(input logic [15:0] a, input logic en);
    if (en && a >= 16'hFE00 && a <= 16'hFF7F) return 4'h9;
    if (a >= FLASH_BYTES) return 4'h8;
    return a < 16'h2 ? 4'h0 : a < 16'h4 ? 4'h1 : a < 16'h6 ? 4'h2 : a < 16'h8 ? 4'h3 :
      a < 16'h38 ? 4'h4 : a < 16'h3A ? 4'h5 : a < 16'h3E ? 4'h6 : 4'h7;
  endfunction
  // -----------------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------------
  task automatic t_rf;
    rf_go(12'h000, 0, 1, 8'h11);
    rf_go(12'h0FF, 0, 1, 8'hC3);
    rf_go(12'h100, 0, 1, 8'hAA);  // gap write aliases ram index 0 if decoded wrongly
    rf_go(12'h000, 1, 0, 8'h00);
    chk("ram 000", 8'h11, q);
    rf_go(12'h0FF, 1, 0, 8'h00);
    chk("ram 0FF", 8'hC3, q);
    rf_go(12'h100, 1, 0, 8'h00);
    chk("gap 100", 8'h00, q);
    rf_go(12'hEFF, 1, 0, 8'h00);
    chk("gap EFF", 8'h00, q);
    rf_go(12'hF05, 1, 0, 8'h00);
    chk("ctrl F05", 8'h39, q);
    rf_go(12'hF20, 1, 0, 8'h00);  // absent register, read only
    chk("ctrl F20", 8'h00, q);
    @(posedge clk_sys);
    dm_rd <= 1'b1;
    dm_wr <= 1'b1;
    @(posedge clk_sys);
    dm_rd <= 1'b0;
    dm_wr <= 1'b0;
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk("data valid", 8'h01, {7'h0, dm_valid});
    chk("data space", 8'hFF, dm_rdata);
  endtask
  task automatic t_vec;
    for (i = 0; i < 18; i++) begin
      pm_go(vec[i], 0, 8'h00);
      chk("pm data", vec[i] < FLASH_BYTES ? vec[i][7:0] + 8'h11 : 8'hFF, q);
      chk("pm region", {4'h0, exp_reg(vec[i], 0)}, {4'h0, r});
    end
    pm_go(16'h0400, 1, 8'h5A);  // dropped write; would alias flash index 0
    pm_go(16'h0000, 0, 8'h00);
    chk("flash 000", 8'h11, q);
  endtask
  task automatic t_info;
    pm_go(16'hFE40, 0, 8'h00);
    chk("overlay off", 8'hFF, q);
    rf_go(12'hFF9, 0, 1, 8'h80);
    rf_go(12'hFF9, 1, 0, 8'h00);
    chk("page select", 8'h80, q);
    pm_go(16'hFE40, 1, 8'hA5);  // overlay write must be dropped
    pm_go(16'h0240, 0, 8'h00);  // flash index it would alias
    chk("flash 240", 8'h51, q);
    pm_go(16'hFE40, 0, 8'h00);
    chk("id first", 8'h47, q);
    chk("info region", 8'h09, {4'h0, r});
    pm_go(16'hFE4C, 0, 8'h00);
    chk("id last", 8'h38, q);
    pm_go(16'hFE53, 0, 8'h00);
    chk("id pad", 8'hFF, q);
    pm_go(16'hFF80, 0, 8'h00);
    chk("past overlay", 8'h08, {4'h0, r});
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(negedge clk_sys);
    chk("enable after reset", 8'h00, {7'h0, info_en});
    pm_go(16'hFE40, 0, 8'h00);
    chk("overlay reset", 8'h08, {4'h0, r});
  endtask
  task automatic end_sim;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // -----------------------------------------------------------------
  // clock, reset, sequence and watchdog
  // -----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  initial begin
    {rst_n, rf_rd, rf_wr, pm_rd, pm_wr, dm_rd, dm_wr} = '0;
    {rf_addr, pm_addr, rf_wdata, pm_wdata} = '0;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_rf();
    t_vec();
    t_info();
    end_sim();
  end
  // whole run is well under two hundred cycles
  initial begin
    repeat (5000) @(posedge clk_sys);
    errors++;
    end_sim();
  end
endmodule
`default_nettype wire
